// >>> design/ppa_ports.sv
`timescale 1ns/1ps
module ppa_ports (
  input wire logic mclk_i,
  input wire logic reset_i,
  // i/o bus
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  output logic [7:0] io_rdata_o,
  // first port
  input wire logic [7:0] first_port_pin_i,
  output logic [7:0] first_port_pin_o,
  output logic [7:0] first_port_oe_n_o,
  // second port
  input wire logic [7:0] second_port_pin_i,
  output logic [7:0] second_port_pin_o,
  output logic [7:0] second_port_oe_n_o,
  input wire logic [1:0] slave_drive_i,
  output logic slave_port_enable_o,
  input wire logic serial_a_int_clk_en_i,
  input wire logic serial_a_clk_i,
  input wire logic serial_b_int_clk_en_i,
  input wire logic serial_b_clk_i,
  // third port
  input wire logic [3:0] third_port_in_i,
  output logic [3:0] third_port_out_o,
  input wire logic serial_a_transmit_i,
  input wire logic serial_b_transmit_i,
  input wire logic serial_c_transmit_i,
  input wire logic serial_d_transmit_i,
  // serial receive routing
  input wire logic [1:0] alt_rx_pin_i,
  input wire logic serial_a_alt_sel_i,
  input wire logic serial_b_alt_sel_i,
  output logic [3:0] serial_rx_o
);
  import ppa_pkg::*;

  // ==========================================================
  // pin synchronisers
  localparam int SYNC_W = 22;

  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic [7:0] first_pins;
  logic [7:0] second_pins;
  logic [3:0] third_pins;
  logic [1:0] alt_pins;

  assign pins_async = {alt_rx_pin_i, third_port_in_i, second_port_pin_i, first_port_pin_i};

  ppa_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  assign first_pins = pins_sync[7:0];
  assign second_pins = pins_sync[15:8];
  assign third_pins = pins_sync[19:16];
  assign alt_pins = pins_sync[21:20];

  // ==========================================================
  // address decode
  wire sel_slc = (io_addr_i == SLAVE_LINK_CONTROL_OFS);
  wire sel_pa = (io_addr_i == PORT_A_DATA_OFS);
  wire sel_pb = (io_addr_i == PORT_B_DATA_OFS);
  wire sel_pc = (io_addr_i == PORT_C_DATA_OFS);
  wire sel_pcf = (io_addr_i == PORT_C_PIN_FUNCTION_OFS);

  wire wr_slc = io_wr_i & sel_slc;
  wire wr_pa = io_wr_i & sel_pa;
  wire wr_pb = io_wr_i & sel_pb;
  wire wr_pc = io_wr_i & sel_pc;
  wire wr_pcf = io_wr_i & sel_pcf;

  // ==========================================================
  // registers
  logic [7:0] slave_link_control;
  logic [7:0] port_a_data;
  logic [1:0] port_b_out;
  logic [3:0] port_c_out;
  logic [3:0] port_c_func;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      slave_link_control <= SLAVE_LINK_CONTROL_RST;
    end else if (wr_slc) begin
      slave_link_control <= io_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      port_a_data <= PORT_A_DATA_RST;
    end else if (wr_pa) begin
      port_a_data <= io_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      port_b_out <= PORT_B_OUT_RST;
    end else if (wr_pb) begin
      port_b_out <= io_wdata_i[7:6];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      port_c_out <= PORT_C_OUT_RST;
    end else if (wr_pc) begin
      port_c_out <= {io_wdata_i[6], io_wdata_i[4], io_wdata_i[2], io_wdata_i[0]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      port_c_func <= PORT_C_FUNC_RST;
    end else if (wr_pcf) begin
      port_c_func <= {io_wdata_i[6], io_wdata_i[4], io_wdata_i[2], io_wdata_i[0]};
    end
  end

  // ==========================================================
  // first port drive
  logic slave_enable;
  logic first_drive;

  assign slave_enable = (slave_link_control[SLC_MODE_LSB +: SLC_MODE_W] != 2'h0);
  assign first_drive = slave_link_control[SLC_DIR_OUT_BIT] & ~slave_enable;
  assign slave_port_enable_o = slave_enable;

  assign first_port_pin_o = port_a_data;
  assign first_port_oe_n_o = {8{~first_drive}};

  // ==========================================================
  // second port drive
  logic [1:0] second_upper_drive;
  logic second_b0_drive;
  logic second_b1_drive;

  assign second_upper_drive = slave_enable ? slave_drive_i : port_b_out;
  assign second_b0_drive = serial_b_int_clk_en_i;
  assign second_b1_drive = serial_a_int_clk_en_i;

  assign second_port_pin_o = {second_upper_drive, 4'h0, serial_a_clk_i, serial_b_clk_i};
  assign second_port_oe_n_o = {2'b00, 4'hf, ~second_b1_drive, ~second_b0_drive};

  // ==========================================================
  // third port drive
  logic [3:0] tx_bus;
  logic [3:0] third_drive;

  assign tx_bus = {serial_a_transmit_i, serial_b_transmit_i, serial_c_transmit_i, serial_d_transmit_i};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_third
      assign third_drive[g] = port_c_func[g] ? tx_bus[g] : port_c_out[g];
    end
  endgenerate

  assign third_port_out_o = third_drive;

  // ==========================================================
  // serial receive routing
  logic [3:0] next_rx;

  always_comb begin
    next_rx = third_pins;
    next_rx[3] = serial_a_alt_sel_i ? alt_pins[1] : third_pins[3];
    next_rx[2] = serial_b_alt_sel_i ? alt_pins[0] : third_pins[2];
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      serial_rx_o <= 4'h0;
    end else begin
      serial_rx_o <= next_rx;
    end
  end

  // ==========================================================
  // read data
  logic [7:0] rd_pa;
  logic [7:0] rd_pb;
  logic [7:0] rd_pc;
  logic [7:0] next_rdata;

  assign rd_pa = first_pins;
  assign rd_pb = {second_upper_drive, second_pins[5:0]};
  assign rd_pc = {third_pins[3], third_drive[3], third_pins[2], third_drive[2],
                  third_pins[1], third_drive[1], third_pins[0], third_drive[0]};

  always_comb begin
    if (sel_slc) begin
      next_rdata = slave_link_control;
    end else if (sel_pa) begin
      next_rdata = rd_pa;
    end else if (sel_pb) begin
      next_rdata = rd_pb;
    end else if (sel_pc) begin
      next_rdata = rd_pc;
    end else begin
      next_rdata = UNMAPPED_READ;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      io_rdata_o <= UNMAPPED_READ;
    end else if (io_rd_i) begin
      io_rdata_o <= next_rdata;
    end
  end

endmodule

// >>> inc/ppa_pkg.sv
// ==========================================================
// constants for the three parallel ports
package ppa_pkg;

  // ==========================================================
  // register offsets in the i/o space
  localparam logic [7:0] SLAVE_LINK_CONTROL_OFS = 8'h24;
  localparam logic [7:0] PORT_A_DATA_OFS = 8'h30;
  localparam logic [7:0] PORT_B_DATA_OFS = 8'h40;
  localparam logic [7:0] PORT_C_DATA_OFS = 8'h50;
  localparam logic [7:0] PORT_C_PIN_FUNCTION_OFS = 8'h55;

  // ==========================================================
  // slave link control fields
  localparam int SLC_DIR_OUT_BIT = 2;
  localparam int SLC_MODE_LSB = 0;
  localparam int SLC_MODE_W = 2;
  localparam logic [7:0] SLC_PORT_A_INPUT = 8'h80;
  localparam logic [7:0] SLC_PORT_A_OUTPUT = 8'h84;

  // ==========================================================
  // reset values
  localparam logic [7:0] SLAVE_LINK_CONTROL_RST = 8'h00;
  localparam logic [7:0] PORT_A_DATA_RST = 8'h00;
  localparam logic [1:0] PORT_B_OUT_RST = 2'h0;
  localparam logic [3:0] PORT_C_OUT_RST = 4'h0;
  localparam logic [3:0] PORT_C_FUNC_RST = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

// >>> design/ppa_sync.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser, one chain per bit
module ppa_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import ppa_pkg::*;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic [SYNC_STAGES-1:0] chain;
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          chain <= '0;
        end else begin
          chain <= {chain[SYNC_STAGES-2:0], async_i[g]};
        end
      end
      assign sync_o[g] = chain[SYNC_STAGES-1];
    end
  endgenerate

endmodule

// >>> verif/ppa_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// external circuitry on one 8-bit port
module ppa_pin_model (
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_o
);
  // an external driver overrides the port; released lines pull up
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      pin_o[j] = ext_en_i[j] ? ext_i[j] : (!oe_n_i[j] ? out_i[j] : 1'b1);
    end
  end
endmodule

// >>> verif/ppa_ports_properties.sv
`timescale 1ns/1ps
// ==========================================================
// port checks
module ppa_ports_props (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic [7:0] first_port_pin_i,
  input wire logic [7:0] first_port_pin_o,
  input wire logic [7:0] first_port_oe_n_o,
  input wire logic [7:0] second_port_pin_o,
  input wire logic [7:0] second_port_oe_n_o,
  input wire logic [1:0] slave_drive_i,
  input wire logic slave_port_enable_o,
  input wire logic serial_a_int_clk_en_i,
  input wire logic serial_a_clk_i,
  input wire logic serial_b_int_clk_en_i,
  input wire logic serial_b_clk_i,
  input wire logic [3:0] third_port_out_o,
  input wire logic serial_a_transmit_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire wr_ctl = io_wr_i && io_addr_i == 8'h24;
  sequence s_route_a;
    io_wr_i && io_addr_i == 8'h55 && io_wdata_i[6] ##1 1'b1;
  endsequence
  sequence s_pins_still;
    $stable(first_port_pin_i)[*3] ##0 io_rd_i && io_addr_i == 8'h30;
  endsequence
  property p_wr_a; io_wr_i && io_addr_i == 8'h30 |=> first_port_pin_o == $past(io_wdata_i); endproperty
  a_wr_a: assert property (p_wr_a) else $error("first port data not stored");
  property p_dir_in; wr_ctl && io_wdata_i == 8'h80 |=> first_port_oe_n_o == 8'hff; endproperty
  a_dir_in: assert property (p_dir_in) else $error("first port still driven");
  property p_dir_out; wr_ctl && io_wdata_i == 8'h84 |=> first_port_oe_n_o == 8'h00; endproperty
  a_dir_out: assert property (p_dir_out) else $error("first port not driven");
  property p_b_wr; io_wr_i && io_addr_i == 8'h40 && !slave_port_enable_o
    |=> second_port_pin_o[7:6] == $past(io_wdata_i[7:6]); endproperty
  a_b_wr: assert property (p_b_wr) else $error("second port outputs wrong");
  property p_slave; slave_port_enable_o |-> second_port_pin_o[7:6] == slave_drive_i; endproperty
  a_slave: assert property (p_slave) else $error("slave drive not on lines");
  property p_clk_b; serial_b_int_clk_en_i |-> second_port_pin_o[0] == serial_b_clk_i && !second_port_oe_n_o[0];
  endproperty
  a_clk_b: assert property (p_clk_b) else $error("line 0 lacks clock");
  property p_clk_a; serial_a_int_clk_en_i |-> second_port_pin_o[1] == serial_a_clk_i && !second_port_oe_n_o[1];
  endproperty
  a_clk_a: assert property (p_clk_a) else $error("line 1 lacks clock");
  property p_rst; $fell(reset_i) |-> first_port_oe_n_o == 8'hff && second_port_pin_o[7:6] == 2'h0
    && third_port_out_o == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_route_a; s_route_a |-> third_port_out_o[3] == serial_a_transmit_i; endproperty
  a_route_a: assert property (p_route_a) else $error("transmitter a not routed");
  property p_read_a; s_pins_still |=> io_rdata_o == $past(first_port_pin_i); endproperty
  a_read_a: assert property (p_read_a) else $error("first port read not pins");
endmodule
bind ppa_ports ppa_ports_props chk_u (.*);

// >>> verif/ppa_ports_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, g, e); end end
module ppa_ports_test;
  logic mclk_i, reset_i, io_wr_i, io_rd_i, slave_port_enable_o, serial_a_int_clk_en_i, serial_a_clk_i;
  logic serial_b_int_clk_en_i, serial_b_clk_i, serial_a_transmit_i, serial_b_transmit_i, serial_c_transmit_i;
  logic serial_d_transmit_i, serial_a_alt_sel_i, serial_b_alt_sel_i;
  logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, first_port_pin_i, first_port_pin_o, first_port_oe_n_o;
  logic [7:0] second_port_pin_i, second_port_pin_o, second_port_oe_n_o, ext_a, ext_a_en, ext_b, d, r;
  logic [3:0] third_port_in_i, third_port_out_o, serial_rx_o, tx, o;
  logic [1:0] slave_drive_i, alt_rx_pin_i;
  int fails, samples_checked, seed, k;
  assign {serial_a_transmit_i, serial_b_transmit_i, serial_c_transmit_i, serial_d_transmit_i} = tx;
  ppa_ports dut_u (.*);
  ppa_pin_model pa_u (.out_i(first_port_pin_o), .oe_n_i(first_port_oe_n_o), .ext_i(ext_a), .ext_en_i(ext_a_en),
    .pin_o(first_port_pin_i));
  ppa_pin_model pb_u (.out_i(second_port_pin_o), .oe_n_i(second_port_oe_n_o), .ext_i(ext_b),
    .ext_en_i({2'h0, second_port_oe_n_o[5:0]}), .pin_o(second_port_pin_i));
  // ==========================================================
  // helpers
  function automatic logic [7:0] cexp(input logic [3:0] ov, input logic [3:0] iv);
    for (int j = 0; j < 4; j++) cexp[2*j +: 2] = {iv[j], ov[j]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk_i) {io_wr_i, io_addr_i, io_wdata_i} = {1'b1, a, v};
    @(negedge mclk_i) io_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk_i) {io_rd_i, io_addr_i} = {1'b1, a};
    @(negedge mclk_i) io_rd_i = 0;
    v = io_rdata_o;
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #500000 fails++;
    close_out;
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 869; fails = 0; samples_checked = 0; reset_i = 1; io_wr_i = 0; io_rd_i = 0; io_addr_i = 0;
    io_wdata_i = 0; ext_a = 0; ext_a_en = 0; ext_b = 0; slave_drive_i = 0; tx = 0; third_port_in_i = 0;
    alt_rx_pin_i = 0; {serial_a_int_clk_en_i, serial_a_clk_i, serial_b_int_clk_en_i, serial_b_clk_i} = 0;
    {serial_a_alt_sel_i, serial_b_alt_sel_i} = 0;
    repeat (10) @(negedge mclk_i);
    reset_i = 0;
    `CHK(first_port_oe_n_o, 8'hff)
    `CHK(second_port_pin_o[7:6], 2'h0)
    `CHK(third_port_out_o, 4'h0)
    d = $random(seed);
    wr(8'h24, 8'h84);
    wr(8'h30, d);
    `CHK(first_port_oe_n_o, 8'h00)
    repeat (3) @(negedge mclk_i);
    rd(8'h30, r); `CHK(r, d)
    ext_a_en = 8'hff; ext_a = ~d;
    repeat (3) @(negedge mclk_i);
    rd(8'h30, r); `CHK(r, ~d)
    ext_a_en = 0;
    wr(8'h24, 8'h80); `CHK(first_port_oe_n_o, 8'hff)
    for (k = 0; k < 4; k++) begin
      d = $random(seed); ext_b = $random(seed);
      wr(8'h40, d); `CHK(second_port_pin_o[7:6], d[7:6])
      repeat (3) @(negedge mclk_i);
      rd(8'h40, r); `CHK(r, {d[7:6], ext_b[5:0]})
    end
    {serial_a_int_clk_en_i, serial_b_int_clk_en_i} = 2'h3;
    repeat (4) begin
      @(negedge mclk_i) {serial_a_clk_i, serial_b_clk_i} = $random(seed);
      #1 `CHK(second_port_pin_o[1:0], {serial_a_clk_i, serial_b_clk_i})
    end
    {serial_a_int_clk_en_i, serial_b_int_clk_en_i} = 2'h0;
    slave_drive_i = ~d[7:6];
    // slave mode on: the second port upper lines carry the slave drive until it is off again
    wr(8'h24, 8'h81); `CHK(second_port_pin_o[7:6], ~d[7:6])
    `CHK(slave_port_enable_o, 1'b1)
    rd(8'h40, r); `CHK(r[7:6], ~d[7:6])
    rd(8'h24, r); `CHK(r, 8'h81)
    wr(8'h24, 8'h80);
    d = $random(seed); third_port_in_i = $random(seed);
    o = {d[6], d[4], d[2], d[0]}; tx = ~o;
    wr(8'h50, d); `CHK(third_port_out_o, o)
    for (k = 0; k < 4; k++) begin
      wr(8'h55, 8'h01 << (2 * k)); `CHK(third_port_out_o[k], tx[k])
      rd(8'h50, r); `CHK(r, cexp(o ^ (4'h1 << k), third_port_in_i))
    end
    wr(8'h55, 8'h00);
    rd(8'h55, r); `CHK(r, 8'h00)
    for (k = 0; k < 2; k++) begin
      {serial_a_alt_sel_i, serial_b_alt_sel_i} = {2{k[0]}};
      alt_rx_pin_i = $random(seed); third_port_in_i = $random(seed);
      repeat (5) @(negedge mclk_i);
      `CHK(serial_rx_o, {k[0] ? alt_rx_pin_i : third_port_in_i[3:2], third_port_in_i[1:0]})
    end
    close_out;
  end
endmodule
